// ===== hw/fsc_pkg.sv
/*
 * fsc_pkg: shared constants for the fifo and system control register bank.
 * assumes: byte-wide register port, offsets as printed, single 200 MHz clock.
 */
`default_nettype none

package fsc_pkg;

    // ========================================================================
    // register offsets
    localparam logic [7:0] ADDR_ITEM_SEL_A = 8'h09;
    localparam logic [7:0] ADDR_ITEM_SEL_B = 8'h0a;
    localparam logic [7:0] ADDR_SYS_CTRL   = 8'h0d;

    // ========================================================================
    // reset values
    localparam logic [7:0] RST_ITEM_SEL_A  = 8'h00;
    localparam logic [7:0] RST_ITEM_SEL_B  = 8'h00;
    localparam logic [4:0] RST_SYS_CTRL    = 5'h00;

    // ========================================================================
    // system control bit positions and width of the implemented part
    localparam int SC_RESET_BIT   = 0;
    localparam int SC_SAVE_BIT    = 1;
    localparam int SC_FIFO_EN_BIT = 2;
    localparam int SC_LP_BIT      = 3;
    localparam int SC_EXTCLK_BIT  = 4;
    localparam int SC_WIDTH       = 5;

    // ========================================================================
    // item selector nibbles
    localparam int ITEM_LO_LSB = 0;
    localparam int ITEM_HI_LSB = 4;
    localparam logic [3:0] ITEM_TYPE_NONE = 4'h0;

    // ========================================================================
    // fifo depth used by the almost-full compare
    localparam logic [5:0] FIFO_DEPTH = 6'h20;

    // ========================================================================
    // sample-rate codes at or below 100 samples per second
    localparam logic [3:0] SR_SINGLE_100 = 4'h4;
    localparam logic [3:0] SR_DUAL_FIRST = 4'hb;

    // ========================================================================
    // length of the forced power-on-reset sequence, in clock cycles
    localparam int RESET_SEQ_CYCLES = 16;

    // power sequencer states
    typedef enum logic [1:0] {
        FSC_RUN   = 2'b00,
        FSC_DRAIN = 2'b01,
        FSC_SAVE  = 2'b10,
        FSC_RESET = 2'b11
    } fsc_pwr_state_t;

endpackage

`default_nettype wire

// ===== hw/fsc_pwr_if.sv
/*
 * fsc_pwr_if: handshake between the register bank and its power sequencer.
 * assumes: both ends run on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

interface fsc_pwr_if;
    logic save_req;     // power-save bit as written
    logic conv_busy;    // a conversion is in flight
    logic reset_req;    // one-cycle pulse: start forced reset
    logic in_save;      // power-save state reached
    logic enter_save;   // one-cycle pulse on entry to power-save
    logic osc_run;      // oscillator enable
    logic reset_busy;   // forced reset sequence running
    logic reset_done;   // one-cycle pulse at end of sequence

    modport regs (output save_req, conv_busy, reset_req,
                  input  in_save, enter_save, osc_run, reset_busy, reset_done);
    modport seq  (input  save_req, conv_busy, reset_req,
                  output in_save, enter_save, osc_run, reset_busy, reset_done);
endinterface

`default_nettype wire

// ===== hw/fsc_power_seq.sv
/*
 * fsc_power_seq: power-save entry and forced reset sequencing.
 * assumes: requests come from the register bank on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

module fsc_power_seq #(
    parameter int RESET_CYCLES = fsc_pkg::RESET_SEQ_CYCLES
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // link to the register bank
    fsc_pwr_if.seq    pwr
);
    localparam int CW = $clog2(RESET_CYCLES + 1);

    fsc_pkg::fsc_pwr_state_t state_q;
    fsc_pkg::fsc_pwr_state_t state_d;
    logic [CW-1:0]           cnt_q;
    logic [CW-1:0]           cnt_d;
    logic                    cnt_end;

    // ========================================================================
    // next state: reset beats everything, drain waits for the conversion
    assign cnt_end = (cnt_q == CW'(RESET_CYCLES - 1));

    always_comb begin
        state_d = state_q;
        cnt_d   = '0;
        case (state_q)
            fsc_pkg::FSC_RUN: begin
                if (pwr.reset_req) begin
                    state_d = fsc_pkg::FSC_RESET;
                end else if (pwr.save_req) begin
                    state_d = pwr.conv_busy ? fsc_pkg::FSC_DRAIN : fsc_pkg::FSC_SAVE;
                end
            end
            fsc_pkg::FSC_DRAIN: begin
                if (pwr.reset_req) begin
                    state_d = fsc_pkg::FSC_RESET;
                end else if (!pwr.save_req) begin
                    state_d = fsc_pkg::FSC_RUN;
                end else if (!pwr.conv_busy) begin
                    state_d = fsc_pkg::FSC_SAVE;
                end
            end
            fsc_pkg::FSC_SAVE: begin
                if (pwr.reset_req) begin
                    state_d = fsc_pkg::FSC_RESET;
                end else if (!pwr.save_req) begin
                    state_d = fsc_pkg::FSC_RUN;
                end
            end
            fsc_pkg::FSC_RESET: begin
                cnt_d = cnt_q + CW'(1);
                if (cnt_end) begin
                    state_d = fsc_pkg::FSC_RUN;
                    cnt_d   = '0;
                end
            end
            default: begin
                state_d = fsc_pkg::FSC_RUN;
            end
        endcase
    end

    // ========================================================================
    // state and counter registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= fsc_pkg::FSC_RUN;
            cnt_q   <= '0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
        end
    end

    // ========================================================================
    // status back to the register bank
    assign pwr.in_save    = (state_q == fsc_pkg::FSC_SAVE);
    assign pwr.enter_save = (state_d == fsc_pkg::FSC_SAVE) &&
                            (state_q != fsc_pkg::FSC_SAVE);
    assign pwr.osc_run    = (state_q != fsc_pkg::FSC_SAVE);
    assign pwr.reset_busy = (state_q == fsc_pkg::FSC_RESET);
    assign pwr.reset_done = (state_q == fsc_pkg::FSC_RESET) && cnt_end;

endmodule

`default_nettype wire

// ===== hw/fsc_regs.sv
/*
 * fsc_regs: fifo item selectors and system control of the optical front end.
 * assumes: a byte-wide register port driven by the serial front end on clk;
 * fifo count, threshold, sample-rate code and conversion status come from
 * logic on the same clock; the two 32 kHz clocks arrive from other domains.
 */
`timescale 1ns/1ps
`default_nettype none

module fsc_regs #(
    parameter int RESET_CYCLES = fsc_pkg::RESET_SEQ_CYCLES
) (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // register port
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    // fifo status from the fifo logic, almost-full, push enable and flush back to it
    input  wire logic [5:0] fifo_count,
    input  wire logic [3:0] afull_thresh,
    output logic            almost_full,
    output logic            fifo_push_en,
    output logic            fifo_flush,
    // sampling engine
    input  wire logic [3:0] sample_rate_code,
    input  wire logic       conv_busy,
    output logic            conv_en,
    output logic      [3:0] item_one_type,
    output logic      [3:0] item_two_type,
    output logic      [3:0] item_three_type,
    output logic      [3:0] item_four_type,
    output logic            dyn_powerdown,
    // 32 kHz clock sources
    input  wire logic       osc_32k_int,
    input  wire logic       ext_clock_pin,
    output logic            clk_32k_sel,
    output logic            ext_clock_used,
    output logic            osc_en,
    // power and reset status
    output logic            power_save_state,
    output logic            irq_flags_clear,
    output logic            sys_reset
);
    // ========================================================================
    // state
    logic [7:0]          sel_a_q;
    logic [7:0]          sel_b_q;
    logic [fsc_pkg::SC_WIDTH-1:0] ctl_q;
    logic [fsc_pkg::SC_WIDTH-1:0] ctl_d;
    logic [7:0]          rdata_q;
    logic                afull_q;
    logic                flush_q;
    logic                conv_run_q;
    logic                clk_sel_q;
    logic                irq_clr_q;
    logic [1:0]          int_sync_q;
    logic [1:0]          ext_sync_q;

    fsc_pwr_if pwr ();

    // ========================================================================
    // functions
    function automatic logic rate_is_slow(input logic [3:0] code);
        rate_is_slow = (code <= fsc_pkg::SR_SINGLE_100) || (code >= fsc_pkg::SR_DUAL_FIRST);
    endfunction

    function automatic logic [7:0] sys_ctrl_view(input logic [fsc_pkg::SC_WIDTH-1:0] c);
        sys_ctrl_view = {{(8 - fsc_pkg::SC_WIDTH){1'b0}}, c};
    endfunction

    // ========================================================================
    // decode
    wire        wr_ok       = reg_wr && !pwr.reset_busy;
    wire        wr_sel_a    = wr_ok && (reg_addr == fsc_pkg::ADDR_ITEM_SEL_A);
    wire        wr_sel_b    = wr_ok && (reg_addr == fsc_pkg::ADDR_ITEM_SEL_B);
    wire        wr_ctl      = wr_ok && (reg_addr == fsc_pkg::ADDR_SYS_CTRL);
    wire [fsc_pkg::SC_WIDTH-1:0] ctl_wr_val = reg_wdata[fsc_pkg::SC_WIDTH-1:0];
    wire        fifo_en_now = ctl_q[fsc_pkg::SC_FIFO_EN_BIT];
    wire        fifo_en_set = wr_ctl && ctl_wr_val[fsc_pkg::SC_FIFO_EN_BIT] && !fifo_en_now;
    wire        reset_req   = wr_ctl && ctl_wr_val[fsc_pkg::SC_RESET_BIT];
    wire        slow_rate   = rate_is_slow(sample_rate_code);
    wire        use_ext     = ctl_q[fsc_pkg::SC_EXTCLK_BIT] && slow_rate;
    wire [3:0]  fd1         = sel_a_q[fsc_pkg::ITEM_LO_LSB +: 4];
    wire        fd1_none    = (fd1 == fsc_pkg::ITEM_TYPE_NONE);
    wire [5:0]  afull_level = fsc_pkg::FIFO_DEPTH - {2'b00, afull_thresh};

    // ========================================================================
    // read mux: unmapped offsets read zero
    wire [7:0] rd_mux =
        (reg_addr == fsc_pkg::ADDR_ITEM_SEL_A) ? sel_a_q :
        (reg_addr == fsc_pkg::ADDR_ITEM_SEL_B) ? sel_b_q :
        (reg_addr == fsc_pkg::ADDR_SYS_CTRL)   ? sys_ctrl_view(ctl_q) :
        8'h00;

    // ========================================================================
    // next system control value; the reset bit stays set until the sequence ends
    always_comb begin
        ctl_d = ctl_q;
        if (pwr.reset_done) begin
            ctl_d = fsc_pkg::RST_SYS_CTRL;
        end else if (wr_ctl) begin
            ctl_d = ctl_wr_val;
        end
    end

    // ========================================================================
    // item selector registers, restored by the forced reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sel_a_q <= fsc_pkg::RST_ITEM_SEL_A;
            sel_b_q <= fsc_pkg::RST_ITEM_SEL_B;
        end else if (pwr.reset_done) begin
            sel_a_q <= fsc_pkg::RST_ITEM_SEL_A;
            sel_b_q <= fsc_pkg::RST_ITEM_SEL_B;
        end else begin
            if (wr_sel_a) begin
                sel_a_q <= reg_wdata;
            end
            if (wr_sel_b) begin
                sel_b_q <= reg_wdata;
            end
        end
    end

    // ========================================================================
    // system control register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctl_q <= fsc_pkg::RST_SYS_CTRL;
        end else begin
            ctl_q <= ctl_d;
        end
    end

    // ========================================================================
    // read data register, loaded on each read strobe
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_q <= 8'h00;
        end else if (reg_rd) begin
            rdata_q <= rd_mux;
        end
    end

    // ========================================================================
    // almost-full compare against the free-space threshold
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            afull_q <= 1'b0;
        end else begin
            afull_q <= (fifo_count == afull_level);
        end
    end

    // ========================================================================
    // flush pulse when fifo enable goes from 0 to 1
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flush_q <= 1'b0;
        end else begin
            flush_q <= fifo_en_set && !pwr.reset_done;
        end
    end

    // ========================================================================
    // conversion run flag: started by fifo enable, ended by item one none
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            conv_run_q <= 1'b0;
        end else if (pwr.reset_done) begin
            conv_run_q <= 1'b0;
        end else if (fifo_en_set) begin
            conv_run_q <= 1'b1;
        end else if (fd1_none) begin
            conv_run_q <= 1'b0;
        end
    end

    // ========================================================================
    // pin and oscillator synchronisers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            int_sync_q <= 2'b00;
            ext_sync_q <= 2'b00;
        end else begin
            int_sync_q <= {int_sync_q[0], osc_32k_int};
            ext_sync_q <= {ext_sync_q[0], ext_clock_pin};
        end
    end

    // ========================================================================
    // selected 32 kHz level; held low while the oscillator is stopped
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            clk_sel_q <= 1'b0;
        end else if (!pwr.osc_run) begin
            clk_sel_q <= 1'b0;
        end else begin
            clk_sel_q <= use_ext ? ext_sync_q[1] : int_sync_q[1];
        end
    end

    // ========================================================================
    // interrupt-flag clear pulse on entry to power-save
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_clr_q <= 1'b0;
        end else begin
            irq_clr_q <= pwr.enter_save;
        end
    end

    // ========================================================================
    // power sequencer link
    assign pwr.save_req  = ctl_q[fsc_pkg::SC_SAVE_BIT];
    assign pwr.conv_busy = conv_busy;
    assign pwr.reset_req = reset_req;

    fsc_power_seq #(
        .RESET_CYCLES (RESET_CYCLES)
    ) u_seq (
        .clk (clk),
        .rst (rst),
        .pwr (pwr)
    );

    // ========================================================================
    // outputs
    assign reg_rdata        = rdata_q;
    assign almost_full      = afull_q;
    assign fifo_push_en     = fifo_en_now && !pwr.reset_busy;
    assign fifo_flush       = flush_q;
    assign conv_en          = conv_run_q && !pwr.in_save && !pwr.reset_busy;
    assign item_one_type    = sel_a_q[fsc_pkg::ITEM_LO_LSB +: 4];
    assign item_two_type    = sel_a_q[fsc_pkg::ITEM_HI_LSB +: 4];
    assign item_three_type  = sel_b_q[fsc_pkg::ITEM_LO_LSB +: 4];
    assign item_four_type   = sel_b_q[fsc_pkg::ITEM_HI_LSB +: 4];
    assign dyn_powerdown    = ctl_q[fsc_pkg::SC_LP_BIT] && slow_rate &&
                              conv_run_q && !conv_busy;
    assign clk_32k_sel      = clk_sel_q;
    assign ext_clock_used   = use_ext;
    assign osc_en           = pwr.osc_run;
    assign power_save_state = pwr.in_save;
    assign irq_flags_clear  = irq_clr_q;
    assign sys_reset        = pwr.reset_busy;

endmodule

`default_nettype wire

// ===== tb/fsc_regs_asserts.sv
/*
 * fsc_regs_asserts: concurrent checks on the ports of fsc_regs.
 * assumes: bound into fsc_regs, single clock, async active-high reset.
 */
`timescale 1ns/1ps
`default_nettype none

module fsc_regs_asserts #(
    parameter int RESET_CYCLES = fsc_pkg::RESET_SEQ_CYCLES
) (
    // clock and reset
    input wire logic       clk,
    input wire logic       rst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    // fifo and sampling
    input wire logic [5:0] fifo_count,
    input wire logic [3:0] afull_thresh,
    input wire logic       almost_full,
    input wire logic       fifo_push_en,
    input wire logic       fifo_flush,
    input wire logic [3:0] sample_rate_code,
    input wire logic       conv_busy,
    input wire logic [3:0] item_one_type,
    input wire logic [3:0] item_two_type,
    input wire logic [3:0] item_three_type,
    input wire logic [3:0] item_four_type,
    input wire logic       dyn_powerdown,
    input wire logic       ext_clock_used,
    // power and reset
    input wire logic       osc_en,
    input wire logic       power_save_state,
    input wire logic       irq_flags_clear,
    input wire logic       sys_reset
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // ========================================================================
    // length of the forced reset sequence
    logic [7:0] seq_cnt_q;
    logic [7:0] seq_cnt_d;
    logic       slow_rate;
    assign seq_cnt_d = sys_reset ? seq_cnt_q + 8'h01 : 8'h00;
    assign slow_rate = (sample_rate_code <= 4'h4) || (sample_rate_code >= 4'hb);

    // count high cycles of the forced reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            seq_cnt_q <= 8'h00;
        end else begin
            seq_cnt_q <= seq_cnt_d;
        end
    end

    // ========================================================================
    // properties
    property p_afull;
        1'b1 |=> almost_full == ($past(fifo_count) == 6'h20 - {2'h0, $past(afull_thresh)});
    endproperty
    a_afull: assert property (p_afull) else $error("almost full mismatch");
    property p_sel_a;
        reg_wr && reg_addr == fsc_pkg::ADDR_ITEM_SEL_A && !sys_reset
            |=> {item_two_type, item_one_type} == $past(reg_wdata);
    endproperty
    a_sel_a: assert property (p_sel_a) else $error("items one two wrong");
    property p_sel_b;
        reg_wr && reg_addr == fsc_pkg::ADDR_ITEM_SEL_B && !sys_reset
            |=> {item_four_type, item_three_type} == $past(reg_wdata);
    endproperty
    a_sel_b: assert property (p_sel_b) else $error("items three four wrong");
    property p_ext_slow;
        ext_clock_used |-> slow_rate;
    endproperty
    a_ext_slow: assert property (p_ext_slow) else $error("ext clock at fast rate");
    property p_lp_slow;
        dyn_powerdown |-> slow_rate && !conv_busy;
    endproperty
    a_lp_slow: assert property (p_lp_slow) else $error("power down misused");
    property p_flush;
        $rose(fifo_push_en) |-> fifo_flush ##1 !fifo_flush;
    endproperty
    a_flush: assert property (p_flush) else $error("flush pulse wrong");
    property p_irq_clr;
        $rose(power_save_state) |-> irq_flags_clear ##1 !irq_flags_clear;
    endproperty
    a_irq_clr: assert property (p_irq_clr) else $error("irq clear pulse wrong");
    property p_osc;
        osc_en != power_save_state;
    endproperty
    a_osc: assert property (p_osc) else $error("oscillator state wrong");
    property p_drain;
        !power_save_state && conv_busy |=> !power_save_state;
    endproperty
    a_drain: assert property (p_drain) else $error("save entered mid conversion");
    property p_swrst;
        $fell(sys_reset) |-> seq_cnt_q == 8'(RESET_CYCLES) && item_one_type == 4'h0;
    endproperty
    a_swrst: assert property (p_swrst) else $error("forced reset wrong");
    property p_rsvd;
        reg_rd && reg_addr == fsc_pkg::ADDR_SYS_CTRL |=> reg_rdata[7:5] == 3'h0;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bits nonzero");
endmodule

bind fsc_regs fsc_regs_asserts #(.RESET_CYCLES(RESET_CYCLES)) u_chk (
    .clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .fifo_count,
    .afull_thresh, .almost_full, .fifo_push_en, .fifo_flush, .sample_rate_code,
    .conv_busy, .item_one_type, .item_two_type, .item_three_type, .item_four_type,
    .dyn_powerdown, .ext_clock_used, .osc_en, .power_save_state, .irq_flags_clear,
    .sys_reset
);

`default_nettype wire

// ===== tb/fsc_regs_tb.sv
/*
 * fsc_regs_tb: self-checking bench for fsc_regs.
 * assumes: the bench drives all inputs on the falling clock edge, except the two free-running 32 kHz stand-ins.
 */
`timescale 1ns/1ps
`default_nettype none

module fsc_regs_tb;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic [7:0] exp;
    } fsc_row_t;

    // ========================================================================
    // signals
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic       reg_wr, reg_rd, almost_full, fifo_push_en, fifo_flush;
    logic [5:0] fifo_count;
    logic [3:0] afull_thresh, sample_rate_code;
    logic [3:0] item_one_type, item_two_type, item_three_type, item_four_type;
    logic       conv_busy, conv_en, dyn_powerdown, clk_32k_sel, ext_clock_used;
    logic       osc_32k_int = 1'b0;
    logic       ext_clock_pin = 1'b0;
    logic       osc_en, power_save_state, irq_flags_clear, sys_reset, seen;
    int         n_fail = 0;
    int         n_compared = 0;
    fsc_row_t   rows [5] = '{'{8'h09, 8'ha5, 8'ha5}, '{8'h0a, 8'h5a, 8'h5a},
                            '{8'h0d, 8'hf8, 8'h18}, '{8'h0d, 8'h00, 8'h00},
                            '{8'h33, 8'hff, 8'h00}};

    // clocks: core and two free-running 32 kHz stand-ins
    always #2.5 clk = ~clk;
    always #37 osc_32k_int = ~osc_32k_int;
    always #53 ext_clock_pin = ~ext_clock_pin;

    fsc_regs #(.RESET_CYCLES(4)) dut_u (
        .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .fifo_count(fifo_count), .afull_thresh(afull_thresh), .almost_full(almost_full),
        .fifo_push_en(fifo_push_en), .fifo_flush(fifo_flush),
        .sample_rate_code(sample_rate_code), .conv_busy(conv_busy), .conv_en(conv_en),
        .item_one_type(item_one_type), .item_two_type(item_two_type),
        .item_three_type(item_three_type), .item_four_type(item_four_type),
        .dyn_powerdown(dyn_powerdown), .osc_32k_int(osc_32k_int),
        .ext_clock_pin(ext_clock_pin), .clk_32k_sel(clk_32k_sel),
        .ext_clock_used(ext_clock_used), .osc_en(osc_en),
        .power_save_state(power_save_state), .irq_flags_clear(irq_flags_clear),
        .sys_reset(sys_reset)
    );

    // ========================================================================
    // helpers
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    // one write strobe, released a cycle later
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
    endtask

    // one read strobe; data is valid after the taking edge
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        chk(reg_rdata, exp, "readback");
    endtask

    task automatic wrap_up;
        if (n_fail == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // watchdog against a hung sequence
    initial begin
        #50000;
        n_fail++;
        wrap_up();
    end

    // ========================================================================
    // main sequence
    initial begin
        {reg_addr, reg_wdata, reg_wr, reg_rd, conv_busy} = '0;
        fifo_count = 6'h00;
        afull_thresh = 4'h0;
        sample_rate_code = 4'h4;
        repeat (20) @(negedge clk);
        rst = 1'b0;
        rd_chk(fsc_pkg::ADDR_ITEM_SEL_A, 8'h00);
        rd_chk(fsc_pkg::ADDR_ITEM_SEL_B, 8'h00);
        rd_chk(fsc_pkg::ADDR_SYS_CTRL, 8'h00);
        foreach (rows[i]) begin
            wr(rows[i].addr, rows[i].wdata);
            rd_chk(rows[i].addr, rows[i].exp);
        end
        chk({item_two_type, item_one_type}, 8'ha5, "items a");
        chk({item_four_type, item_three_type}, 8'h5a, "items b");
        // almost full at every threshold and one below it
        for (int t = 0; t < 16; t++) begin
            afull_thresh = 4'(t);
            fifo_count = 6'(32 - t);
            @(negedge clk);
            @(negedge clk);
            chk({7'h0, almost_full}, 8'h01, "afull hit");
            fifo_count = 6'(31 - t);
            @(negedge clk);
            @(negedge clk);
            chk({7'h0, almost_full}, 8'h00, "afull miss");
        end
        // clock source and low power by sample rate
        wr(fsc_pkg::ADDR_SYS_CTRL, 8'h18);
        chk({7'h0, ext_clock_used}, 8'h01, "ext slow");
        sample_rate_code = 4'h5;
        @(negedge clk);
        chk({7'h0, ext_clock_used}, 8'h00, "ext fast");
        sample_rate_code = 4'hb;
        wr(fsc_pkg::ADDR_SYS_CTRL, 8'h1c);
        chk({6'h0, fifo_flush, fifo_push_en}, 8'h03, "flush");
        @(negedge clk);
        chk({6'h0, fifo_flush, conv_en}, 8'h01, "flush end");
        chk({7'h0, dyn_powerdown}, 8'h01, "lp slow");
        sample_rate_code = 4'ha;
        @(negedge clk);
        chk({7'h0, dyn_powerdown}, 8'h00, "lp fast");
        // fifo disable keeps conversions until item one is none
        wr(fsc_pkg::ADDR_SYS_CTRL, 8'h18);
        chk({6'h0, fifo_push_en, conv_en}, 8'h01, "hold");
        wr(fsc_pkg::ADDR_ITEM_SEL_A, 8'ha0);
        @(negedge clk);
        chk({7'h0, conv_en}, 8'h00, "item none");
        // power save requested mid conversion
        wr(fsc_pkg::ADDR_ITEM_SEL_A, 8'ha5);
        wr(fsc_pkg::ADDR_SYS_CTRL, 8'h04);
        conv_busy = 1'b1;
        wr(fsc_pkg::ADDR_SYS_CTRL, 8'h06);
        repeat (4) @(negedge clk);
        chk({6'h0, power_save_state, osc_en}, 8'h01, "drain");
        conv_busy = 1'b0;
        seen = 1'b0;
        for (int k = 0; k < 6; k++) begin
            @(negedge clk);
            seen |= irq_flags_clear;
        end
        chk({3'h0, conv_en, clk_32k_sel, seen, power_save_state, osc_en}, 8'h06, "save");
        wr(fsc_pkg::ADDR_ITEM_SEL_B, 8'h77);
        rd_chk(fsc_pkg::ADDR_ITEM_SEL_B, 8'h77);
        rd_chk(fsc_pkg::ADDR_SYS_CTRL, 8'h06);
        wr(fsc_pkg::ADDR_SYS_CTRL, 8'h04);
        repeat (2) @(negedge clk);
        chk({6'h0, power_save_state, osc_en}, 8'h01, "wake");
        // forced reset, with a write that lands inside it
        wr(fsc_pkg::ADDR_SYS_CTRL, 8'h05);
        chk({7'h0, sys_reset}, 8'h01, "swrst on");
        wr(fsc_pkg::ADDR_ITEM_SEL_A, 8'hff);
        for (int k = 0; k < 50 && sys_reset === 1'b1; k++) @(negedge clk);
        chk({7'h0, sys_reset}, 8'h00, "swrst end");
        rd_chk(fsc_pkg::ADDR_ITEM_SEL_A, 8'h00);
        rd_chk(fsc_pkg::ADDR_ITEM_SEL_B, 8'h00);
        rd_chk(fsc_pkg::ADDR_SYS_CTRL, 8'h00);
        // external reset in mid run
        wr(fsc_pkg::ADDR_ITEM_SEL_B, 8'h33);
        rst = 1'b1;
        @(negedge clk);
        rst = 1'b0;
        rd_chk(fsc_pkg::ADDR_ITEM_SEL_B, 8'h00);
        wrap_up();
    end
endmodule

`default_nettype wire
